// file: hw/fs_defs.svh
`ifndef FS_DEFS_SVH
`define FS_DEFS_SVH

// ----------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------
`define FS_ADDR_W      13
`define FS_ADDR_MIN    13'h0000
`define FS_ADDR_MAX    13'h1FFF
`define FS_AHI_USED    5

// ----------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------
`define FS_BIT_FIRST   3'h0
`define FS_BIT_LAST    3'h7
`define FS_RW_READ     1'b1
`define FS_SEL_W       3

`endif

// file: hw/fs_pkg.sv
package fs_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_DEV,
        S_AHI,
        S_ALO,
        S_WR,
        S_ACK,
        S_RD,
        S_RACK
    } fs_state_t;

    // link-domain state
    typedef struct packed {
        fs_state_t   state;
        fs_state_t   nxt;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_p;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_p;
        logic        wp_s1;
        logic        wp_s2;
        logic [2:0]  sel_s1;
        logic [2:0]  sel_s2;
        logic [2:0]  bit_cnt;
        logic [7:0]  sh;
        logic [7:0]  ahi;
        logic [12:0] addr;
        logic        ack_go;
        logic        ack_ph;
        logic        mack;
        logic        drive;
        logic        commit_tgl;
        logic        active;
    } fs_link_t;

    // system-clock state
    typedef struct packed {
        logic ev_s1;
        logic ev_s2;
        logic ev_s3;
        logic act_s1;
        logic act_s2;
        logic wr_pulse;
    } fs_sys_t;

endpackage

// file: hw/fs_mem_array.sv
`timescale 1ns/100ps

module fs_mem_array #(
    parameter int ADDR_W = 13
) (
    input  wire logic              clk_in,
    input  wire logic              we_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        wdata_in,
    output logic      [7:0]        rdata_out
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_width
        $error("fs_mem_array: ADDR_W out of range");
    end

    // ----------------------------------------------------------------
    // array
    // ----------------------------------------------------------------
    // no reset: contents are nonvolatile, while the whole link and system-clock state of fs_slave resets
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end

endmodule

// file: hw/fs_slave.sv
`timescale 1ns/100ps
`include "fs_defs.svh"

module fs_slave #(
    // arbitrary value, stands in for the device-type field
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    input  wire logic                 mclk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 link_clk_in,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_out,
    input  wire logic                 wp_in,
    input  wire logic [`FS_SEL_W-1:0] device_select_pins_in,
    output logic                      byte_written_out,
    output logic                      link_busy_out
);

    fs_pkg::fs_link_t       st_q;
    fs_pkg::fs_link_t       st_d;
    fs_pkg::fs_sys_t        sy_q;
    fs_pkg::fs_sys_t        sy_d;
    logic                   rise;
    logic                   fall;
    logic                   start_c;
    logic                   stop_c;
    logic                   byte_end;
    logic [7:0]             rx_byte;
    logic                   mem_we;
    logic [7:0]             mem_rdata;

    function automatic logic [`FS_ADDR_W-1:0] inc_addr(input logic [`FS_ADDR_W-1:0] a);
        // natural roll-over from the top location to zero
        inc_addr = (a == `FS_ADDR_MAX) ? `FS_ADDR_MIN : a + `FS_ADDR_W'(1);
    endfunction

    // ----------------------------------------------------------------
    // bus conditions
    // ----------------------------------------------------------------
    // first sync stage feeds only the second; edges use stage two and its delay
    assign rise     = st_q.scl_s2 & ~st_q.scl_p;
    assign fall     = ~st_q.scl_s2 & st_q.scl_p;
    assign start_c  = st_q.scl_s2 & st_q.scl_p & st_q.sda_p & ~st_q.sda_s2;
    assign stop_c   = st_q.scl_s2 & st_q.scl_p & ~st_q.sda_p & st_q.sda_s2;
    assign byte_end = rise & (st_q.bit_cnt == `FS_BIT_LAST);
    assign rx_byte  = {st_q.sh[6:0], st_q.sda_s2};

    assign sda_out    = 1'b0;
    assign sda_oe_out = st_q.drive;

    fs_mem_array #(
        .ADDR_W    (`FS_ADDR_W)
    ) u_mem (
        .clk_in    (link_clk_in),
        .we_in     (mem_we),
        .addr_in   (st_q.addr),
        .wdata_in  (rx_byte),
        .rdata_out (mem_rdata)
    );

    // ----------------------------------------------------------------
    // link-side state machine
    // ----------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        mem_we      = 1'b0;
        st_d.scl_s1 = scl_in;
        st_d.scl_s2 = st_q.scl_s1;
        st_d.scl_p  = st_q.scl_s2;
        st_d.sda_s1 = sda_in;
        st_d.sda_s2 = st_q.sda_s1;
        st_d.sda_p  = st_q.sda_s2;
        // pad pull-down keeps this low when open
        st_d.wp_s1  = wp_in;
        st_d.wp_s2  = st_q.wp_s1;
        st_d.sel_s1 = device_select_pins_in;
        st_d.sel_s2 = st_q.sel_s1;

        if (stop_c) begin
            st_d.state  = fs_pkg::S_IDLE;
            st_d.drive  = 1'b0;
            st_d.ack_ph = 1'b0;
        end else if (start_c) begin
            st_d.state   = fs_pkg::S_DEV;
            st_d.bit_cnt = `FS_BIT_FIRST;
            st_d.drive   = 1'b0;
            st_d.ack_ph  = 1'b0;
        end else begin
            case (st_q.state)
                fs_pkg::S_DEV, fs_pkg::S_AHI, fs_pkg::S_ALO, fs_pkg::S_WR: begin
                    if (rise) begin
                        st_d.sh      = rx_byte;
                        st_d.bit_cnt = st_q.bit_cnt + 3'h1;
                    end
                    if (byte_end) begin
                        st_d.state  = fs_pkg::S_ACK;
                        st_d.ack_go = 1'b1;
                        st_d.ack_ph = 1'b0;
                        case (st_q.state)
                            fs_pkg::S_DEV: begin
                                if (rx_byte[7:4] != DEV_TYPE ||
                                    rx_byte[3:1] != st_q.sel_s2) begin
                                    st_d.state = fs_pkg::S_IDLE;
                                end else if (rx_byte[0] == `FS_RW_READ) begin
                                    st_d.nxt = fs_pkg::S_RD;
                                end else begin
                                    st_d.nxt = fs_pkg::S_AHI;
                                end
                            end
                            fs_pkg::S_AHI: begin
                                st_d.ahi = rx_byte;
                                st_d.nxt = fs_pkg::S_ALO;
                            end
                            fs_pkg::S_ALO: begin
                                st_d.addr = {st_q.ahi[`FS_AHI_USED-1:0], rx_byte};
                                st_d.nxt  = fs_pkg::S_WR;
                            end
                            default: begin
                                st_d.nxt = fs_pkg::S_WR;
                                if (st_q.wp_s2) begin
                                    // no ack, no write, no advance
                                    st_d.ack_go = 1'b0;
                                end else begin
                                    mem_we          = 1'b1;
                                    st_d.commit_tgl = ~st_q.commit_tgl;
                                    st_d.addr       = inc_addr(st_q.addr);
                                end
                            end
                        endcase
                    end
                end
                fs_pkg::S_ACK: begin
                    if (fall && !st_q.ack_ph) begin
                        st_d.ack_ph = 1'b1;
                        st_d.drive  = st_q.ack_go;
                    end else if (fall) begin
                        st_d.ack_ph  = 1'b0;
                        st_d.state   = st_q.nxt;
                        st_d.bit_cnt = `FS_BIT_FIRST;
                        st_d.drive   = 1'b0;
                        if (st_q.nxt == fs_pkg::S_RD) begin
                            st_d.sh    = mem_rdata;
                            st_d.drive = ~mem_rdata[7];
                            st_d.addr  = inc_addr(st_q.addr);
                        end
                    end
                end
                fs_pkg::S_RD: begin
                    if (fall && st_q.bit_cnt == `FS_BIT_LAST) begin
                        st_d.drive   = 1'b0;
                        st_d.state   = fs_pkg::S_RACK;
                        st_d.bit_cnt = `FS_BIT_FIRST;
                    end else if (fall) begin
                        st_d.sh      = {st_q.sh[6:0], 1'b0};
                        st_d.drive   = ~st_q.sh[6];
                        st_d.bit_cnt = st_q.bit_cnt + 3'h1;
                    end
                end
                fs_pkg::S_RACK: begin
                    if (rise) begin
                        st_d.mack = ~st_q.sda_s2;
                    end
                    if (fall && st_q.mack) begin
                        st_d.state = fs_pkg::S_RD;
                        st_d.sh    = mem_rdata;
                        st_d.drive = ~mem_rdata[7];
                        st_d.addr  = inc_addr(st_q.addr);
                    end else if (fall) begin
                        st_d.state = fs_pkg::S_IDLE;
                    end
                end
                default: begin
                    st_d.drive = 1'b0;
                end
            endcase
        end
        st_d.active = (st_d.state != fs_pkg::S_IDLE);
    end

    always_ff @(posedge link_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q       <= '0;
            st_q.state <= fs_pkg::S_IDLE;
            st_q.nxt   <= fs_pkg::S_IDLE;
            st_q.addr  <= `FS_ADDR_MIN;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // system-clock side
    // ----------------------------------------------------------------
    // commit toggle crosses as an event; busy crosses as a level
    always_comb begin
        sy_d          = sy_q;
        sy_d.ev_s1    = st_q.commit_tgl;
        sy_d.ev_s2    = sy_q.ev_s1;
        sy_d.ev_s3    = sy_q.ev_s2;
        sy_d.act_s1   = st_q.active;
        sy_d.act_s2   = sy_q.act_s1;
        sy_d.wr_pulse = sy_q.ev_s2 ^ sy_q.ev_s3;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sy_q <= '0;
        end else begin
            sy_q <= sy_d;
        end
    end

    assign byte_written_out = sy_q.wr_pulse;
    assign link_busy_out    = sy_q.act_s2;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_commit_then_ack;
        @(posedge link_clk_in) disable iff (!resetn_in)
        mem_we |=> (st_q.state == fs_pkg::S_ACK) && st_q.ack_go && !st_q.ack_ph;
    endproperty
    a_commit_then_ack: assert property (p_commit_then_ack)
        else $error("write not followed by pending ack");

    property p_wp_blocks;
        @(posedge link_clk_in) disable iff (!resetn_in)
        st_q.wp_s2 |-> !mem_we;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks)
        else $error("write while protected");

    property p_wp_addr_hold;
        @(posedge link_clk_in) disable iff (!resetn_in)
        (st_q.state == fs_pkg::S_WR && byte_end && st_q.wp_s2 && !start_c && !stop_c)
            |=> (st_q.addr == $past(st_q.addr)) && !st_q.ack_go;
    endproperty
    a_wp_addr_hold: assert property (p_wp_addr_hold)
        else $error("protected write moved address or acked");

    property p_write_wrap;
        @(posedge link_clk_in) disable iff (!resetn_in)
        (mem_we && st_q.addr == `FS_ADDR_MAX) |=> (st_q.addr == `FS_ADDR_MIN);
    endproperty
    a_write_wrap: assert property (p_write_wrap)
        else $error("write address did not wrap");

    property p_stop_release;
        @(posedge link_clk_in) disable iff (!resetn_in)
        stop_c |=> !st_q.drive && (st_q.state == fs_pkg::S_IDLE) && $stable(st_q.addr);
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("stop did not release and idle");

    property p_start_keeps;
        @(posedge link_clk_in) disable iff (!resetn_in)
        (start_c && !stop_c) |=> (st_q.state == fs_pkg::S_DEV) && $stable(st_q.addr);
    endproperty
    a_start_keeps: assert property (p_start_keeps)
        else $error("start lost address or state");

    property p_read_first;
        @(posedge link_clk_in) disable iff (!resetn_in)
        (st_q.state == fs_pkg::S_ACK && st_q.ack_ph && fall && !start_c && !stop_c
            && st_q.nxt == fs_pkg::S_RD)
            |=> (st_q.state == fs_pkg::S_RD) && (st_q.drive == ~$past(mem_rdata[7]));
    endproperty
    a_read_first: assert property (p_read_first)
        else $error("read did not start driving data");

    property p_read_next;
        @(posedge link_clk_in) disable iff (!resetn_in)
        (st_q.state == fs_pkg::S_RACK && fall && st_q.mack && !start_c && !stop_c)
            |=> (st_q.addr == inc_addr($past(st_q.addr))) && (st_q.state == fs_pkg::S_RD);
    endproperty
    a_read_next: assert property (p_read_next)
        else $error("acked read did not advance");

    property p_no_match;
        @(posedge link_clk_in) disable iff (!resetn_in)
        (st_q.state == fs_pkg::S_DEV && byte_end && !start_c && !stop_c
            && rx_byte[3:1] != st_q.sel_s2)
            |=> (st_q.state == fs_pkg::S_IDLE) ##1 !st_q.drive;
    endproperty
    a_no_match: assert property (p_no_match)
        else $error("responded to foreign select bits");

    c_write: cover property (@(posedge link_clk_in) disable iff (!resetn_in) mem_we);
    c_wp_nack: cover property (@(posedge link_clk_in) disable iff (!resetn_in)
        st_q.state == fs_pkg::S_ACK && !st_q.ack_go && fall);
    c_read_ack: cover property (@(posedge link_clk_in) disable iff (!resetn_in)
        st_q.state == fs_pkg::S_RACK && fall && st_q.mack);
    c_restart_rd: cover property (@(posedge link_clk_in) disable iff (!resetn_in)
        st_q.state == fs_pkg::S_RACK && start_c);

endmodule

// file: sim/fs_bus_master.sv
`timescale 1ns/100ps

module fs_bus_master #(
    parameter int HALF = 4
) (
    input  wire logic       mclk_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            sda_low_out,
    output logic            res_valid_out,
    output logic [8:0]      res_out
);
    // ------------------------------------------------------------
    // bus idle: both lines released
    // ------------------------------------------------------------
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        res_valid_out = 1'b0;
        res_out = 9'h000;
    end

    task automatic half();
        repeat (HALF) @(posedge mclk_in);
    endtask

    task automatic report(input logic [8:0] r);
        res_out <= r;
        res_valid_out <= 1'b1;
        @(posedge mclk_in);
        res_valid_out <= 1'b0;
    endtask

    // sda moves one cycle after scl falls: hold time, no false start
    task automatic put_bit(input logic b);
        @(posedge mclk_in);
        sda_low_out <= ~b;
        half();
        scl_out <= 1'b1;
        half();
        scl_out <= 1'b0;
    endtask

    task automatic get_bit(output logic b);
        @(posedge mclk_in);
        sda_low_out <= 1'b0;
        half();
        scl_out <= 1'b1;
        half();
        b = sda_in;
        scl_out <= 1'b0;
    endtask

    task automatic start_cond();
        @(posedge mclk_in);
        sda_low_out <= 1'b0;
        half();
        scl_out <= 1'b1;
        half();
        sda_low_out <= 1'b1;
        half();
        scl_out <= 1'b0;
    endtask

    task automatic stop_cond();
        @(posedge mclk_in);
        sda_low_out <= 1'b1;
        half();
        scl_out <= 1'b1;
        half();
        sda_low_out <= 1'b0;
        half();
    endtask

    // byte out msb first, ack bit reported
    task automatic wr_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        report({1'b0, 7'h00, a});
    endtask

    // mode 0 ack, 1 nack, 2 no ninth bit
    task automatic rd_byte(input logic [1:0] mode);
        logic [7:0] d;
        logic       b;
        d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            get_bit(b);
            d = {d[6:0], b};
        end
        report({1'b1, d});
        if (mode != 2'h2) begin
            put_bit(mode[0]);
        end
    endtask
endmodule

// file: sim/fs_slave_test.sv
`timescale 1ns/100ps

module fs_slave_test;
    localparam logic [3:0] DEV = 4'h5; // arbitrary device-type value
    logic        mclk, link_clk, resetn, wp, scl, mst_low, dut_sda, dut_oe;
    logic        sda_wire, wr_pulse, busy, res_valid;
    logic [2:0]  sel;
    logic [8:0]  res;
    logic [12:0] cur;
    logic [8:0]  exp_q[$];
    logic [7:0]  ref_mem[8192];
    int          error_cnt, compares, commits, exp_commits;

    // open-drain line with pull-up
    assign sda_wire = (mst_low || (dut_oe && !dut_sda)) ? 1'b0 : 1'b1;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    fs_slave #(.DEV_TYPE(DEV)) u_dut (
        .mclk_in(mclk), .resetn_in(resetn), .link_clk_in(link_clk), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(dut_sda), .sda_oe_out(dut_oe), .wp_in(wp),
        .device_select_pins_in(sel), .byte_written_out(wr_pulse), .link_busy_out(busy));

    fs_bus_master #(.HALF(4)) u_mst (
        .mclk_in(mclk), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(mst_low),
        .res_valid_out(res_valid), .res_out(res));

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic fail(input string m);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic cmp_res(input logic [8:0] e, input logic [8:0] g);
        compares++;
        if (g !== e) fail($sformatf("bus result %h, wanted %h", g, e));
    endtask
    task automatic cmp_busy(input logic e, input logic g);
        compares++;
        if (g !== e) fail($sformatf("busy %b, wanted %b", g, e));
    endtask
    task automatic cmp_cnt(input int e, input int g);
        compares++;
        if (g != e) fail($sformatf("commit count %0d, wanted %0d", g, e));
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        if (wr_pulse === 1'b1) commits++;
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0) fail("result without a note");
            else cmp_res(exp_q.pop_front(), res);
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    task automatic wbyte(input logic [7:0] d, input logic nack);
        exp_q.push_back({1'b0, 7'h00, nack});
        u_mst.wr_byte(d);
    endtask
    task automatic hdr(input logic [2:0] s, input logic rw, input logic nack);
        wbyte({DEV, s, rw}, nack);
    endtask
    // junk lands in the ignored top bits of the high byte
    task automatic set_addr(input logic [12:0] a, input logic [2:0] junk);
        u_mst.start_cond();
        hdr(sel, 1'b0, 1'b0);
        cmp_busy(1'b1, busy);
        wbyte({junk, a[12:8]}, 1'b0);
        wbyte(a[7:0], 1'b0);
        cur = a;
    endtask
    task automatic wr_data(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (wp) begin
                wbyte(d, 1'b1);
            end else begin
                wbyte(d, 1'b0);
                ref_mem[cur] = d;
                cur = cur + 13'h0001;
                exp_commits++;
            end
        end
    endtask
    // term: 0 nack+stop, 1 nack+start, 2 stop in 9th, 3 start in 9th
    task automatic rd_data(input int n, input logic [1:0] term);
        u_mst.start_cond();
        hdr(sel, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back({1'b1, ref_mem[cur]});
            cur = cur + 13'h0001;
            if (i < n - 1) u_mst.rd_byte(2'h0);
            else u_mst.rd_byte((term < 2'h2) ? 2'h1 : 2'h2);
        end
        if (term[0]) u_mst.start_cond();
        u_mst.stop_cond();
    endtask
    task automatic end_test(input string name);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 400) begin
            @(posedge mclk);
            k++;
        end
        repeat (10) @(posedge mclk);
        if (exp_q.size() != 0) begin
            fail("bus results missing");
            final_report();
        end else begin
            cmp_cnt(exp_commits, commits);
            cmp_busy(1'b0, busy);
            $display("test %s done", name);
        end
    endtask

    initial begin
        resetn = 1'b0;
        wp = 1'b0;
        cur = 13'h0000;
        void'($urandom(66));
        sel = 3'($urandom);
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        set_addr(13'h1FFE, 3'h7);
        wr_data(4);
        u_mst.stop_cond();
        end_test("write_wrap");
        set_addr(13'h1FFE, 3'h0);
        rd_data(2, 2'h1);
        end_test("random_read");
        rd_data(2, 2'h2);
        end_test("current_read");
        wp <= 1'b1;
        set_addr(13'h0001, 3'h0);
        wr_data(2);
        u_mst.stop_cond();
        wp <= 1'b0;
        rd_data(1, 2'h3);
        end_test("protect");
        set_addr(13'h0000, 3'h0);
        for (int i = 0; i < 5; i++) u_mst.put_bit(1'($urandom));
        u_mst.stop_cond();
        rd_data(1, 2'h0);
        end_test("abort");
        u_mst.start_cond();
        wbyte({~DEV, sel, 1'b1}, 1'b1);
        u_mst.stop_cond();
        u_mst.start_cond();
        hdr(sel ^ 3'h1, 1'b0, 1'b1);
        u_mst.stop_cond();
        u_mst.start_cond();
        hdr(sel, 1'b0, 1'b0);
        u_mst.stop_cond();
        end_test("select_poll");
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        cmp_busy(1'b0, busy);
        cur = 13'h0000;
        rd_data(2, 2'h0);
        end_test("reset_read");
        final_report();
    end

    // hang guard
    initial begin
        #1000000;
        fail("run timed out");
        final_report();
    end
endmodule
